// ---- fwp_defs.svh ----
// Overview of operation
// R1: Origin bit 0 measures top, 1 bottom
// R2: Origin bit non-volatile, factory value 0
// R3: Origin changes only through permitted status write
// R4: Granule bit 1 sectors 4KB, 0 blocks 64KB
// R5: Granule bit non-volatile, default 0 blocks
// R6: Invert bit non-volatile, status bit 14
// R7: Invert set makes region writable, rest read-only
// R8: Invert bit defaults to 0
// R9: Lock bits non-volatile at status 8 and 7
// R10: Lock bits pick one of four schemes
// R11: Locks 00 ignore pin, need write enable
// R12: Locks 01, pin high, need write enable
// R13: Locks 10 refuse until power cycle clears
// R14: Locks 11 refuse status writes forever; here reset clears both lock bits to 00, which allows status writes again
// R15: Locks 01, pin low, always refuse
// R16: Program or erase touching read-only is ignored
`ifndef FWP_DEFS_SVH
`define FWP_DEFS_SVH

`define FWP_OFS_STATUS 8'h00
`define FWP_OFS_COMMAND 8'h04
`define FWP_OFS_ADDR 8'h08
`define FWP_OFS_RESULT 8'h0c

`define FWP_BIT_BUSY 0
`define FWP_BIT_WRITE_LATCH 1
`define FWP_BIT_RANGE_LSB 2
`define FWP_BIT_RANGE_MSB 4
`define FWP_BIT_ORIGIN 5
`define FWP_BIT_GRANULE 6
`define FWP_BIT_LOCK_LOW 7
`define FWP_BIT_LOCK_HIGH 8
`define FWP_BIT_INVERT 14

`define FWP_RST_RANGE 3'h0
`define FWP_RST_ORIGIN 1'b0
`define FWP_RST_GRANULE 1'b0
`define FWP_RST_INVERT 1'b0
`define FWP_RST_LOCK_LOW 1'b0
`define FWP_RST_LOCK_HIGH 1'b0

`define FWP_OP_WREN 4'h1
`define FWP_OP_WRDI 4'h2
`define FWP_OP_WRSR 4'h3
`define FWP_OP_PROG 4'h4
`define FWP_OP_SECT 4'h5
`define FWP_OP_BLK 4'h6
`define FWP_OP_CHIP 4'h7

`define FWP_ARRAY_TOP 20'hfffff
`define FWP_SECT_MASK 20'h00fff
`define FWP_BLK_MASK 20'h0ffff
`define FWP_SECT_SHIFT 12
`define FWP_BLK_SHIFT 16
`define FWP_ARRAY_BYTES 21'h100000

`endif

// ---- fwp_pkg.sv ----
package fwp_pkg;
  typedef logic [19:0] fwp_addr_type;
  typedef enum logic [1:0] {
    FWP_SOFTWARE,
    FWP_HARDWARE,
    FWP_LOCKDOWN,
    FWP_ONE_TIME
  } fwp_scheme_type;
  typedef enum {
    FWP_ST_IDLE,
    FWP_ST_ACCESS
  } fwp_phase_type;
  typedef struct packed {
    fwp_phase_type phase;
    logic write_enable_latch;
    logic [2:0] range_protect;
    logic origin_select;
    logic granule_select;
    logic invert_protection;
    logic status_lock_low;
    logic status_lock_high;
    fwp_addr_type addr;
    logic last_accept;
    logic last_reject;
    logic [31:0] rdata;
    logic op_valid;
    logic [3:0] op_kind;
    fwp_addr_type op_addr;
  } fwp_state_type;
endpackage : fwp_pkg

// ---- fwp_region_check.sv ----
`timescale 1ns/1ps
`include "fwp_defs.svh"
module fwp_region_check import fwp_pkg::*; (
  input wire logic [2:0] range_protect, // Range units code
  input wire logic origin_select, // 0 top, 1 bottom
  input wire logic granule_select, // 1 sectors, 0 blocks
  input wire logic invert_protection, // Invert the map
  input wire fwp_addr_type first_addr, // First byte touched
  input wire fwp_addr_type last_addr, // Last byte touched
  output logic read_only // Some byte touched is read-only
);
  logic [23:0] unit_len;
  logic [23:0] span_full;
  logic [20:0] span;
  logic [20:0] lo;
  logic [20:0] hi;
  logic within_region;
  logic overlap;

  always_comb begin
    unit_len = granule_select ? (24'h1 << `FWP_SECT_SHIFT) : (24'h1 << `FWP_BLK_SHIFT); // R4
    span_full = 24'h0;
    if (range_protect != 3'h0) begin
      span_full = unit_len << (range_protect - 3'h1);
    end
    // Wide enough that the largest block codes cap instead of wrapping
    span = span_full[20:0];
    if (span_full > {3'h0, `FWP_ARRAY_BYTES}) begin
      span = `FWP_ARRAY_BYTES;
    end
    if (origin_select) begin // R1
      lo = 21'h0;
      hi = span - 21'h1;
    end else begin
      lo = `FWP_ARRAY_BYTES - span;
      hi = `FWP_ARRAY_BYTES - 21'h1;
    end
    within_region = (span != 21'h0) && ({1'b0, first_addr} >= lo) && ({1'b0, last_addr} <= hi);
    overlap = (span != 21'h0) && ({1'b0, last_addr} >= lo) && ({1'b0, first_addr} <= hi);
    read_only = invert_protection ? !within_region : overlap; // R7
  end
endmodule : fwp_region_check

// ---- fwp_flash_protect.sv ----
`timescale 1ns/1ps
`include "fwp_defs.svh"
module fwp_flash_protect import fwp_pkg::*; (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Power-on reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic write_protect_n, // Write-protect pin, active low
  output logic array_op_valid, // Accepted array op pulse
  output logic [3:0] array_op_kind, // Accepted op code
  output logic [19:0] array_op_addr // Accepted op address
);
  fwp_state_type s_r;
  fwp_state_type s_nxt;
  fwp_scheme_type scheme;
  logic [15:0] status_word;
  logic status_ok;
  logic mapped;
  logic [3:0] op;
  fwp_addr_type first_addr;
  fwp_addr_type last_addr;
  logic hits_read_only;

  assign op = pwdata[3:0];

  // Range of bytes a pending array op would touch
  always_comb begin
    first_addr = s_r.addr;
    last_addr = s_r.addr;
    case (op)
      `FWP_OP_SECT: begin
        first_addr = s_r.addr & ~`FWP_SECT_MASK;
        last_addr = s_r.addr | `FWP_SECT_MASK;
      end
      `FWP_OP_BLK: begin
        first_addr = s_r.addr & ~`FWP_BLK_MASK;
        last_addr = s_r.addr | `FWP_BLK_MASK;
      end
      `FWP_OP_CHIP: begin
        first_addr = 20'h00000;
        last_addr = `FWP_ARRAY_TOP;
      end
      default: begin
        first_addr = s_r.addr;
        last_addr = s_r.addr;
      end
    endcase
  end

  fwp_region_check u_check (
    .range_protect(s_r.range_protect),
    .origin_select(s_r.origin_select),
    .granule_select(s_r.granule_select),
    .invert_protection(s_r.invert_protection),
    .first_addr(first_addr),
    .last_addr(last_addr),
    .read_only(hits_read_only)
  );

  always_comb begin
    scheme = fwp_scheme_type'({s_r.status_lock_high, s_r.status_lock_low}); // R10
    case (scheme)
      FWP_SOFTWARE: status_ok = s_r.write_enable_latch; // R11
      FWP_HARDWARE: status_ok = s_r.write_enable_latch && write_protect_n; // R12 R15
      FWP_LOCKDOWN: status_ok = 1'b0; // R13
      FWP_ONE_TIME: status_ok = 1'b0; // R14
      default: status_ok = 1'b0;
    endcase
  end

  always_comb begin
    status_word = 16'h0000;
    status_word[`FWP_BIT_BUSY] = 1'b0;
    status_word[`FWP_BIT_WRITE_LATCH] = s_r.write_enable_latch;
    status_word[`FWP_BIT_RANGE_MSB:`FWP_BIT_RANGE_LSB] = s_r.range_protect;
    status_word[`FWP_BIT_ORIGIN] = s_r.origin_select;
    status_word[`FWP_BIT_GRANULE] = s_r.granule_select;
    status_word[`FWP_BIT_LOCK_LOW] = s_r.status_lock_low; // R9
    status_word[`FWP_BIT_LOCK_HIGH] = s_r.status_lock_high;
    status_word[`FWP_BIT_INVERT] = s_r.invert_protection; // R6
  end

  assign mapped = (paddr == `FWP_OFS_STATUS) || (paddr == `FWP_OFS_COMMAND) ||
                  (paddr == `FWP_OFS_ADDR) || (paddr == `FWP_OFS_RESULT);

  always_comb begin
    s_nxt = s_r;
    s_nxt.op_valid = 1'b0;
    case (s_r.phase)
      FWP_ST_IDLE: begin
        if (psel && !penable) begin
          s_nxt.phase = FWP_ST_ACCESS;
          s_nxt.rdata = 32'h00000000;
          if (!pwrite) begin
            case (paddr)
              `FWP_OFS_STATUS: s_nxt.rdata = {16'h0000, status_word};
              `FWP_OFS_ADDR: s_nxt.rdata = {12'h000, s_r.addr};
              `FWP_OFS_RESULT: s_nxt.rdata = {30'h0, s_r.last_reject, s_r.last_accept};
              default: s_nxt.rdata = 32'h00000000;
            endcase
          end
        end
      end
      FWP_ST_ACCESS: begin
        s_nxt.phase = FWP_ST_IDLE;
        if (psel && penable && pwrite) begin
          if (paddr == `FWP_OFS_ADDR) begin
            s_nxt.addr = pwdata[19:0];
          end else if (paddr == `FWP_OFS_COMMAND) begin
            case (op)
              `FWP_OP_WREN: s_nxt.write_enable_latch = 1'b1;
              `FWP_OP_WRDI: s_nxt.write_enable_latch = 1'b0;
              `FWP_OP_WRSR: begin
                s_nxt.write_enable_latch = 1'b0;
                s_nxt.last_accept = status_ok;
                s_nxt.last_reject = !status_ok;
                if (status_ok) begin // R3
                  s_nxt.range_protect =
                    pwdata[16 + `FWP_BIT_RANGE_MSB:16 + `FWP_BIT_RANGE_LSB];
                  s_nxt.origin_select = pwdata[16 + `FWP_BIT_ORIGIN];
                  s_nxt.granule_select = pwdata[16 + `FWP_BIT_GRANULE];
                  s_nxt.status_lock_low = pwdata[16 + `FWP_BIT_LOCK_LOW];
                  s_nxt.status_lock_high = pwdata[16 + `FWP_BIT_LOCK_HIGH];
                  s_nxt.invert_protection = pwdata[16 + `FWP_BIT_INVERT];
                end
              end
              `FWP_OP_PROG, `FWP_OP_SECT, `FWP_OP_BLK, `FWP_OP_CHIP: begin
                s_nxt.write_enable_latch = 1'b0;
                if (s_r.write_enable_latch && !hits_read_only) begin // R16
                  s_nxt.last_accept = 1'b1;
                  s_nxt.last_reject = 1'b0;
                  s_nxt.op_valid = 1'b1;
                  s_nxt.op_kind = op;
                  s_nxt.op_addr = first_addr;
                end else begin
                  s_nxt.last_accept = 1'b0;
                  s_nxt.last_reject = 1'b1;
                end
              end
              default: s_nxt.write_enable_latch = s_r.write_enable_latch;
            endcase
          end
        end
      end
      default: s_nxt.phase = FWP_ST_IDLE;
    endcase
  end

  // Reset stands for a power cycle: protection bits return to factory values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.phase <= FWP_ST_IDLE;
      s_r.write_enable_latch <= 1'b0;
      s_r.range_protect <= `FWP_RST_RANGE;
      s_r.origin_select <= `FWP_RST_ORIGIN; // R2
      s_r.granule_select <= `FWP_RST_GRANULE; // R5
      s_r.invert_protection <= `FWP_RST_INVERT; // R8
      s_r.status_lock_low <= `FWP_RST_LOCK_LOW;
      s_r.status_lock_high <= `FWP_RST_LOCK_HIGH; // R13
      s_r.addr <= 20'h00000;
      s_r.last_accept <= 1'b0;
      s_r.last_reject <= 1'b0;
      s_r.rdata <= 32'h00000000;
      s_r.op_valid <= 1'b0;
      s_r.op_kind <= 4'h0;
      s_r.op_addr <= 20'h00000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign array_op_valid = s_r.op_valid;
  assign array_op_kind = s_r.op_kind;
  assign array_op_addr = s_r.op_addr;
endmodule : fwp_flash_protect

// ---- fwp_flash_protect_sva.sv ----
`timescale 1ns/1ps
module fwp_flash_protect_sva (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic write_protect_n, // Pin
  input wire logic array_op_valid, // Op pulse
  input wire logic [3:0] array_op_kind, // Op code
  input wire logic [19:0] array_op_addr // Op address
);
  logic acc;
  logic mapped;
  logic op_wr;
  assign acc = psel && penable;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c};
  assign op_wr = acc && pwrite && paddr == 8'h04 && pwdata[3:0] inside {[4'h4:4'h7]};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_issue;
    op_wr ##1 array_op_valid;
  endsequence
  ready_const_a: assert property (pready) else $error("pready low");
  slverr_map_a: assert property (pslverr == (acc && !mapped)) else $error("pslverr wrong");
  op_cause_a: assert property (array_op_valid |-> $past(op_wr)) else $error("op no cause");
  op_kind_a: assert property (s_issue |-> array_op_kind == $past(pwdata[3:0]))
    else $error("op kind wrong");
  op_pulse_a: assert property (array_op_valid |=> !array_op_valid) else $error("op pulse long");
  op_hold_a: assert property (!array_op_valid |-> $stable(array_op_kind) && $stable(array_op_addr))
    else $error("op not held");
  chip_addr_a: assert property (array_op_valid && array_op_kind == 4'h7 |-> array_op_addr == 20'h0)
    else $error("chip addr");
  erase_align_a: assert property (array_op_valid && array_op_kind == 4'h5 |->
    array_op_addr[11:0] == 12'h0) else $error("sector align");
  cmd_read_a: assert property (acc && !pwrite && (paddr == 8'h04 || !mapped) |-> prdata == 32'h0)
    else $error("read not zero");
  status_rsv_a: assert property (acc && !pwrite && paddr == 8'h00 |->
    prdata[31:15] == 17'h0 && prdata[13:9] == 5'h0 && !prdata[0]) else $error("status reserved");
endmodule : fwp_flash_protect_sva

bind fwp_flash_protect fwp_flash_protect_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .write_protect_n(write_protect_n),
  .array_op_valid(array_op_valid), .array_op_kind(array_op_kind), .array_op_addr(array_op_addr));

// ---- fwp_array_sink.sv ----
`timescale 1ns/1ps
module fwp_array_sink (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic valid, // Op strobe
  input wire logic [19:0] addr, // Op start
  output int count, // Ops taken
  output logic [19:0] last_addr // Last op start
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 0;
      last_addr <= 20'h0;
    end else if (valid) begin
      count <= count + 1;
      last_addr <= addr;
    end
  end
endmodule : fwp_array_sink

// ---- test_flash_array_write_protect_logic.sv ----
`timescale 1ns/1ps
module test_flash_array_write_protect_logic import fwp_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic write_protect_n = 1'b1, pready, pslverr, array_op_valid, err;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] array_op_kind;
  logic [19:0] array_op_addr, sink_addr;
  int bad_count = 0, total_checks = 0, cyc = 0, sink_count;
  fwp_flash_protect u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .write_protect_n(write_protect_n), .array_op_valid(array_op_valid),
    .array_op_kind(array_op_kind), .array_op_addr(array_op_addr));
  fwp_array_sink u_sink (.pclk(pclk), .presetn(presetn), .valid(array_op_valid),
    .addr(array_op_addr), .count(sink_count), .last_addr(sink_addr));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("Checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      $display("ERROR %0t timeout", $time);
      bad_count++;
      complete_run();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk
  task automatic wrsr(input logic [15:0] v, input logic [31:0] exp);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h04, {v, 16'h3});
    rd_chk(8'h00, exp);
  endtask : wrsr
  task automatic op(input logic [3:0] k, input logic [19:0] a, input logic [31:0] res,
                    input logic [19:0] ea);
    int n;
    n = sink_count;
    apb(1'b1, 8'h08, {12'h0, a});
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h04, {28'h0, k});
    rd_chk(8'h0c, res);
    chk(sink_count - n, {31'h0, res == 32'h1});
    if (res == 32'h1) chk({12'h0, sink_addr}, {12'h0, ea});
  endtask : op
  task automatic t_defaults;
    rd_chk(8'h00, 32'h0);
    chk({31'h0, err}, 32'h0);
    rd_chk(8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h04, 32'h00040003);
    rd_chk(8'h0c, 32'h2);
    rd_chk(8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h1);
    rd_chk(8'h00, 32'h2);
    apb(1'b1, 8'h04, 32'h2);
    rd_chk(8'h00, 32'h0);
  endtask : t_defaults
  task automatic t_invert;
    wrsr(16'h406c, 32'h406c);
    op(4'h4, 20'h03fff, 32'h1, 20'h03fff);
    op(4'h4, 20'h04000, 32'h2, 20'h0);
    op(4'h5, 20'h03abc, 32'h1, 20'h03000);
    op(4'h7, 20'h0, 32'h2, 20'h0);
  endtask : t_invert
  task automatic t_top;
    write_protect_n <= 1'b0;
    wrsr(16'h0004, 32'h4);
    write_protect_n <= 1'b1;
    op(4'h6, 20'hf1234, 32'h2, 20'h0);
    op(4'h6, 20'he1234, 32'h1, 20'he0000);
    wrsr(16'h0000, 32'h0);
    op(4'h7, 20'h0, 32'h1, 20'h0);
  endtask : t_top
  task automatic t_locks;
    wrsr(16'h0080, 32'h80);
    write_protect_n <= 1'b0;
    wrsr(16'h0004, 32'h80);
    write_protect_n <= 1'b1;
    wrsr(16'h0100, 32'h100);
    wrsr(16'h0000, 32'h100);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(8'h00, 32'h0);
    wrsr(16'h0180, 32'h180);
    wrsr(16'h0000, 32'h180);
  endtask : t_locks
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_defaults();
    t_invert();
    t_top();
    t_locks();
    complete_run();
  end
endmodule : test_flash_array_write_protect_logic
